// File: pkg/scg_map.vh
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SCG_ADR_SLEEP_CTRL   8'h00
`define SCG_ADR_GATE         8'h04
`define SCG_ADR_CONFIG       8'h08
`define SCG_ADR_STATUS       8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define SCG_SE_BIT           0
`define SCG_SM_LSB           1
`define SCG_SM_MSB           3
`define SCG_CFG_XTAL_BIT     0
`define SCG_CFG_BOD_BIT      1
`define SCG_CFG_ACREF_BIT    2
`define SCG_GATE_TWI         7
`define SCG_GATE_TIM2        6
`define SCG_GATE_TIM0        5
`define SCG_GATE_RSVD        4
`define SCG_GATE_TIM1        3
`define SCG_GATE_SPI         2
`define SCG_GATE_USART0      1
`define SCG_GATE_ADC         0
`define SCG_GATE_WMASK       8'hEF

// ****************************************************************
// Sleep mode codes
// ****************************************************************
`define SCG_SM_IDLE          3'h0
`define SCG_SM_ADCNR         3'h1
`define SCG_SM_PDOWN         3'h2
`define SCG_SM_PSAVE         3'h3
`define SCG_SM_STANDBY       3'h6

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define SCG_SLEEP_CTRL_RST   4'h0
`define SCG_GATE_RST         8'h00
`define SCG_CONFIG_RST       3'h0
`define SCG_WAKE_HOLD_CYC    8'h04
`define SCG_STANDBY_WAKE_CYC 8'h06
`define SCG_STARTUP_CYC      8'h10

`endif

// File: rtl/scg_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "scg_map.vh"

module scg_ctrl #(
  parameter [7:0] STARTUP_CYC = `SCG_STARTUP_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        sleep_instr_i,
  input  wire        core_gie_i,
  input  wire [1:0]  timer2_irq_mask_reg_i,
  input  wire        timer2_en_i,
  input  wire        timer2_async_select_i,
  input  wire        timer2_ovf_i,
  input  wire        timer2_cmp_i,
  input  wire        ext_irq_zero_i,
  input  wire        ext_irq_one_i,
  input  wire [1:0]  ext_irq_level_i,
  input  wire        pin_change_i,
  input  wire        twi_match_i,
  input  wire        spm_ready_i,
  input  wire        adc_done_i,
  input  wire        wdt_irq_i,
  input  wire        other_io_irq_i,
  input  wire        adc_enable_i,
  input  wire        adc_conv_start_i,
  output reg         cpu_clk_en_o,
  output reg         flash_clk_en_o,
  output reg         io_clk_en_o,
  output reg         adc_clk_en_o,
  output reg         async_timer_clock_en_o,
  output reg         main_osc_en_o,
  output reg         timer_osc_en_o,
  output reg         timer2_sync_clk_en_o,
  output wire [7:0]  periph_clk_en_o,
  output wire [7:0]  periph_reg_access_o,
  output reg         core_resume_o,
  output reg         asleep_o,
  output wire        adc_power_o,
  output wire        adc_ext_conv_o,
  output reg         acmp_disable_o,
  output wire        acmp_mux_allow_o,
  output wire        bod_en_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_ACTIVE = 3'h1;
  localparam [2:0] ST_SLEEP  = 3'h2;
  localparam [2:0] ST_WAKE   = 3'h4;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [2:0] mode_q;
  reg  [2:0] mode_d;
  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  reg  [3:0] sleep_ctrl_q;
  reg  [7:0] gate_q;
  reg  [2:0] config_q;
  reg        adc_en_prev_q;
  reg        ext_conv_q;
  reg  [7:0] periph_clk_q;
  reg  [7:0] periph_acc_q;

  wire       sleep_enable_bit  = sleep_ctrl_q[`SCG_SE_BIT];
  wire [2:0] sleep_mode_select = sleep_ctrl_q[`SCG_SM_MSB:`SCG_SM_LSB];
  wire       xtal_sel          = config_q[`SCG_CFG_XTAL_BIT];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr_lo = wb_req & wb_we_i & wb_sel_i[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sleep_ctrl_q <= `SCG_SLEEP_CTRL_RST;
      gate_q       <= `SCG_GATE_RST;
      config_q     <= `SCG_CONFIG_RST;
    end else if (wb_wr_lo) begin
      case (wb_adr_i)
        `SCG_ADR_SLEEP_CTRL: begin
          sleep_ctrl_q <= wb_dat_i[3:0];
        end
        `SCG_ADR_GATE: begin
          gate_q <= wb_dat_i[7:0] & `SCG_GATE_WMASK;
        end
        `SCG_ADR_CONFIG: begin
          config_q <= wb_dat_i[2:0];
        end
        default: begin
          gate_q <= gate_q;
        end
      endcase
    end
  end

  // Read data is registered with the ack; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req & ~wb_we_i) begin
      case (wb_adr_i)
        `SCG_ADR_SLEEP_CTRL: wb_dat_o <= {28'h000_0000, sleep_ctrl_q};
        `SCG_ADR_GATE:       wb_dat_o <= {24'h00_0000, gate_q};
        `SCG_ADR_CONFIG:     wb_dat_o <= {29'h000_0000, config_q};
        `SCG_ADR_STATUS:     wb_dat_o <= {26'h0, ext_conv_q, mode_q, state_q[2], state_q[1]};
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire sm_ok_std   = (sleep_mode_select == `SCG_SM_STANDBY) & xtal_sel;
  wire sm_valid    = (sleep_mode_select == `SCG_SM_IDLE)  |
                     (sleep_mode_select == `SCG_SM_ADCNR) |
                     (sleep_mode_select == `SCG_SM_PDOWN) |
                     (sleep_mode_select == `SCG_SM_PSAVE) |
                     sm_ok_std;
  wire enter_sleep = sleep_instr_i & sleep_enable_bit & sm_valid;

  wire in_sleep = state_q[1];
  wire m_idle   = in_sleep & (mode_q == `SCG_SM_IDLE);
  wire m_adcnr  = in_sleep & (mode_q == `SCG_SM_ADCNR);
  wire m_pdown  = in_sleep & (mode_q == `SCG_SM_PDOWN);
  wire m_psave  = in_sleep & (mode_q == `SCG_SM_PSAVE);
  wire m_stdby  = in_sleep & (mode_q == `SCG_SM_STANDBY);
  wire m_deep   = m_pdown | m_psave | m_stdby;

  // ****************************************************************
  // Wake sources
  // ****************************************************************
  // Timer2 counts as a source only when its interrupt is truly enabled
  wire t2_wake  = core_gie_i & ((timer2_ovf_i & timer2_irq_mask_reg_i[0]) |
                                (timer2_cmp_i & timer2_irq_mask_reg_i[1]));
  wire ext_any  = ext_irq_zero_i | ext_irq_one_i;
  wire ext_lvl  = (ext_irq_zero_i & ext_irq_level_i[0]) |
                  (ext_irq_one_i & ext_irq_level_i[1]);
  wire base_src = pin_change_i | twi_match_i | wdt_irq_i;

  reg wake_hit;
  always @* begin
    wake_hit = 1'b0;
    if (m_idle) begin
      wake_hit = ext_any | base_src | t2_wake | spm_ready_i | adc_done_i | other_io_irq_i;
    end else if (m_adcnr) begin
      wake_hit = ext_lvl | base_src | t2_wake | spm_ready_i | adc_done_i;
    end else if (m_psave) begin
      wake_hit = ext_lvl | base_src | t2_wake;
    end else if (m_pdown | m_stdby) begin
      wake_hit = ext_lvl | base_src;
    end
  end

  // Power-down and power-save restart the stopped source, so they pay the start-up time
  wire [7:0] wake_len = m_stdby ? `SCG_STANDBY_WAKE_CYC :
                        (m_idle | m_adcnr) ? `SCG_WAKE_HOLD_CYC :
                        STARTUP_CYC + `SCG_WAKE_HOLD_CYC;

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  always @* begin
    state_d = state_q;
    mode_d  = mode_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_ACTIVE: begin
        if (enter_sleep) begin
          state_d = ST_SLEEP;
          mode_d  = sleep_mode_select;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_d = ST_WAKE;
          cnt_d   = wake_len;
        end
      end
      ST_WAKE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
        cnt_d   = 8'h00;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= ST_ACTIVE;
      mode_q        <= `SCG_SM_IDLE;
      cnt_q         <= 8'h00;
      core_resume_o <= 1'b0;
      asleep_o      <= 1'b0;
    end else begin
      state_q       <= state_d;
      mode_q        <= mode_d;
      cnt_q         <= cnt_d;
      core_resume_o <= state_q[2] & (cnt_q == 8'h01);
      asleep_o      <= state_d != ST_ACTIVE;
    end
  end

  // ****************************************************************
  // Clock domain and oscillator enables
  // ****************************************************************
  wire t2_sync = timer2_en_i & ~timer2_async_select_i;
  reg  cpu_d;
  reg  io_d;
  reg  adc_d;
  reg  asy_d;
  reg  main_d;
  reg  tosc_d;
  reg  t2clk_d;

  always @* begin
    cpu_d   = state_q[0];
    io_d    = 1'b1;
    adc_d   = 1'b1;
    asy_d   = 1'b1;
    main_d  = 1'b1;
    tosc_d  = timer2_async_select_i;
    t2clk_d = 1'b1;
    if (m_adcnr) begin
      io_d    = 1'b0;
      t2clk_d = 1'b0;
    end else if (m_pdown) begin
      io_d    = 1'b0;
      adc_d   = 1'b0;
      asy_d   = 1'b0;
      main_d  = 1'b0;
      tosc_d  = 1'b0;
      t2clk_d = 1'b0;
    end else if (m_psave) begin
      io_d    = 1'b0;
      adc_d   = 1'b0;
      main_d  = t2_sync;
      tosc_d  = timer2_async_select_i;
      t2clk_d = t2_sync;
    end else if (m_stdby) begin
      io_d    = 1'b0;
      adc_d   = 1'b0;
      asy_d   = 1'b0;
      tosc_d  = 1'b0;
      t2clk_d = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o           <= 1'b0;
      flash_clk_en_o         <= 1'b0;
      io_clk_en_o            <= 1'b0;
      adc_clk_en_o           <= 1'b0;
      async_timer_clock_en_o <= 1'b0;
      main_osc_en_o          <= 1'b1;
      timer_osc_en_o         <= 1'b0;
      timer2_sync_clk_en_o   <= 1'b0;
    end else begin
      cpu_clk_en_o           <= cpu_d;
      flash_clk_en_o         <= cpu_d;
      io_clk_en_o            <= io_d;
      adc_clk_en_o           <= adc_d;
      async_timer_clock_en_o <= asy_d;
      main_osc_en_o          <= main_d;
      timer_osc_en_o         <= tosc_d;
      timer2_sync_clk_en_o   <= t2clk_d;
    end
  end

  // ****************************************************************
  // Per-peripheral gating
  // ****************************************************************
  // Only the enable is dropped; the peripheral's flops simply hold,
  // which is what lets it resume exactly where it stopped.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gate
      wire dom_on;
      wire stop;
      if (gi == `SCG_GATE_RSVD) begin : g_rsvd
        assign dom_on = 1'b0;
        assign stop   = 1'b1;
      end else if (gi == `SCG_GATE_ADC) begin : g_adc
        assign dom_on = adc_d;
        assign stop   = gate_q[gi];
      end else if (gi == `SCG_GATE_TIM2) begin : g_tim2
        assign dom_on = io_d | t2clk_d;
        assign stop   = gate_q[gi] & ~timer2_async_select_i;
      end else begin : g_io
        assign dom_on = io_d;
        assign stop   = gate_q[gi];
      end
      always @(posedge clk_i) begin
        if (rst_i) begin
          periph_clk_q[gi] <= 1'b0;
          periph_acc_q[gi] <= 1'b0;
        end else begin
          periph_clk_q[gi] <= dom_on & ~stop;
          periph_acc_q[gi] <= ~stop;
        end
      end
    end
  endgenerate

  assign periph_clk_en_o     = periph_clk_q;
  assign periph_reg_access_o = periph_acc_q;

  // ****************************************************************
  // Analog housekeeping
  // ****************************************************************
  // ADC power ignores sleep; software must disable it to save current
  assign adc_power_o      = adc_enable_i;
  assign acmp_mux_allow_o = ~gate_q[`SCG_GATE_ADC];
  assign bod_en_o         = config_q[`SCG_CFG_BOD_BIT];
  assign adc_ext_conv_o   = ext_conv_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      adc_en_prev_q  <= 1'b0;
      ext_conv_q     <= 1'b0;
      acmp_disable_o <= 1'b0;
    end else begin
      adc_en_prev_q <= adc_enable_i;
      // A re-enable in the same cycle as a start keeps the flag set
      if (adc_enable_i & ~adc_en_prev_q) begin
        ext_conv_q <= 1'b1;
      end else if (adc_conv_start_i) begin
        ext_conv_q <= 1'b0;
      end
      acmp_disable_o <= m_deep & ~config_q[`SCG_CFG_ACREF_BIT];
    end
  end

endmodule
`default_nettype wire

// File: dv/scg_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checker
// ****************
module scg_ctrl_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        flash_clk_en_o,
  input wire logic        io_clk_en_o,
  input wire logic        adc_clk_en_o,
  input wire logic        main_osc_en_o,
  input wire logic [7:0]  periph_clk_en_o,
  input wire logic [7:0]  periph_reg_access_o,
  input wire logic        core_resume_o,
  input wire logic        asleep_o,
  input wire logic        adc_enable_i,
  input wire logic        adc_power_o,
  input wire logic        adc_ext_conv_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write to the gate register in its acknowledged cycle
  wire gate_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h04 && wb_sel_i[0];
  a_cpu_flash_pair:
    assert property (cpu_clk_en_o == flash_clk_en_o) else $error("cpu and flash enables differ");
  a_active_domains:
    assert property (cpu_clk_en_o |-> io_clk_en_o && adc_clk_en_o && main_osc_en_o) else $error("active domain off");
  a_entry_stops_cpu:
    assert property ($rose(asleep_o) |=> !cpu_clk_en_o) else $error("cpu clock kept in sleep");
  a_resume_at_exit:
    assert property ($fell(asleep_o) |-> core_resume_o ##1 !core_resume_o) else $error("resume pulse wrong");
  a_resume_cpu_on:
    assert property (core_resume_o |=> cpu_clk_en_o) else $error("cpu clock not back");
  a_gate_set_stops:
    assert property (gate_wr && wb_dat_i[0] |=> !periph_clk_en_o[0] && !periph_reg_access_o[0])
      else $error("gated adc still live");
  a_gate_clear_runs:
    assert property (gate_wr && !wb_dat_i[0] && cpu_clk_en_o |=> periph_clk_en_o[0] && periph_reg_access_o[0])
      else $error("ungated adc not live");
  a_bit4_reads_zero:
    assert property (periph_reg_access_o[4] == 1'h0) else $error("bit 4 access set");
  a_adc_power_kept:
    assert property (adc_power_o == adc_enable_i) else $error("adc power differs");
  a_ext_conv_flag:
    assert property ($rose(adc_enable_i) |=> adc_ext_conv_o) else $error("extended conversion not flagged");
  c_sleep: cover property ($rose(asleep_o));
  c_resume: cover property (core_resume_o);
  c_gate: cover property (gate_wr);
endmodule
bind scg_ctrl scg_ctrl_sva i_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .cpu_clk_en_o, .flash_clk_en_o, .io_clk_en_o, .adc_clk_en_o, .main_osc_en_o, .periph_clk_en_o,
  .periph_reg_access_o, .core_resume_o, .asleep_o, .adc_enable_i, .adc_power_o, .adc_ext_conv_o);
`default_nettype wire

// File: dv/scg_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Core model
// ****************
module scg_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sleep_req_i,
  input  wire logic       wake_i,
  input  wire logic       resume_i,
  output logic            sleep_instr_o,
  output logic [7:0]      wake_cnt_o
);
  logic run_q;
  logic done_q;
  // Sleep instruction one cycle after each sleep request, whether or not sleep enable is set
  always @(posedge clk_i) begin
    sleep_instr_o <= !rst_i && sleep_req_i;
  end
  // Counts edges from the wake request until the core is released
  always @(posedge clk_i) begin
    if (rst_i || sleep_req_i) begin
      wake_cnt_o <= 8'h00;
      run_q      <= 1'h0;
      done_q     <= 1'h0;
    end else if (resume_i) begin
      done_q <= 1'h1;
    end else if (!done_q && (wake_i || run_q)) begin
      wake_cnt_o <= wake_cnt_o + 8'h01;
      run_q      <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/scg_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module scg_ctrl_tb;
  logic clk, rst, cyc, stb, we, ack, sinstr, gie, async, wake, req, adc_en, adc_st;
  logic cpu, fl, io, adcc, asy, mosc, tosc, t2s, resume, asleep, apow, xconv, acmp, mux, bod;
  logic [1:0]  mask, lvl;
  logic [3:0]  sel;
  logic [7:0]  adr, pclk, pacc, cnt;
  logic [9:0]  src;
  logic [31:0] wdat, rdat, q;
  int fails, n_checks;
  scg_ctrl #(.STARTUP_CYC(8'h01)) i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_instr_i(sinstr),
    .core_gie_i(gie), .timer2_irq_mask_reg_i(mask), .timer2_en_i(1'h1), .timer2_async_select_i(async),
    .timer2_ovf_i(src[9]), .timer2_cmp_i(src[8]), .ext_irq_zero_i(src[7]), .ext_irq_one_i(src[6]),
    .ext_irq_level_i(lvl), .pin_change_i(src[5]), .twi_match_i(src[4]), .spm_ready_i(src[3]),
    .adc_done_i(src[2]), .wdt_irq_i(src[1]), .other_io_irq_i(src[0]), .adc_enable_i(adc_en),
    .adc_conv_start_i(adc_st), .cpu_clk_en_o(cpu), .flash_clk_en_o(fl), .io_clk_en_o(io), .adc_clk_en_o(adcc),
    .async_timer_clock_en_o(asy), .main_osc_en_o(mosc), .timer_osc_en_o(tosc), .timer2_sync_clk_en_o(t2s),
    .periph_clk_en_o(pclk), .periph_reg_access_o(pacc), .core_resume_o(resume), .asleep_o(asleep),
    .adc_power_o(apow), .adc_ext_conv_o(xconv), .acmp_disable_o(acmp), .acmp_mux_allow_o(mux), .bod_en_o(bod));
  scg_core_model i_core (.clk_i(clk), .rst_i(rst), .sleep_req_i(req), .wake_i(wake), .resume_i(resume),
    .sleep_instr_o(sinstr), .wake_cnt_o(cnt));
  // ****************
  // Bench tasks
  // ****************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'h1 && n < 50);
    if (n >= 50) fails++;
    q = rdat;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
  endtask
  task automatic pulse_sleep(input logic [3:0] v);
    wb(1'h1, 8'h00, {28'h0, v});
    @(posedge clk) req <= 1'h1;
    @(posedge clk) req <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  // Bad sources must be ignored for a while before the good one wakes
  task automatic slp(input logic [2:0] m, input logic [9:0] bad, input logic [9:0] good,
                     input logic [6:0] ena, input logic [7:0] n);
    int i;
    pulse_sleep({m, 1'h1});
    chk("asleep", asleep, 1);
    chk("domains", {io, adcc, asy, mosc, tosc, t2s, acmp}, ena);
    chk("bod", bod, 1);
    src <= bad;
    repeat (20) @(posedge clk);
    chk("held", asleep, 1);
    src <= good | bad;
    wake <= 1'h1;
    i = 0;
    while (asleep !== 1'h0 && i < 100) begin @(posedge clk); i++; end
    repeat (3) @(posedge clk);
    chk("wake", cnt, n);
    chk("cpu", cpu, 1);
    src <= 10'h000;
    wake <= 1'h0;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    {rst, cyc, stb, we, gie, async, wake, req, adc_en, adc_st} = 10'h200;
    {mask, lvl, sel, adr, src, wdat} = 58'h0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    async <= 1'h1;
    for (int i = 0; i < 5; i++) begin wb(1'h0, 8'(i * 4), 0); chk("reset", q, 0); end
    $display("test reset done");
    wb(1'h1, 8'h04, 32'hFF);
    wb(1'h0, 8'h04, 0); chk("gate", q, 32'hEF);
    chk("mux", mux, 0);
    chk("access", pacc, 8'h40);
    chk("pclk", pclk & 8'hEF, 8'h40);
    async <= 1'h0;
    wb(1'h1, 8'h04, 32'h40); @(posedge clk); chk("t2 sync", pclk & 8'hEF, 8'hAF);
    async <= 1'h1;
    wb(1'h1, 8'h04, 0); @(posedge clk); chk("ungate", pacc, 8'hEF);
    chk("mux on", mux, 1);
    $display("test gate done");
    for (int i = 0; i < 3; i++) begin pulse_sleep({3'h4 + 3'(i + i / 2), 1'h1}); chk("rsvd", asleep, 0); end
    pulse_sleep(4'hD); chk("no xtal", asleep, 0);
    pulse_sleep(4'h0); chk("no enable", asleep, 0);
    $display("test refuse done");
    wb(1'h1, 8'h08, 32'h03); chk("bod", bod, 1);
    slp(3'h0, 10'h000, 10'h001, 7'h7E, 8'h05);
    slp(3'h1, 10'h001, 10'h002, 7'h3C, 8'h05);
    slp(3'h2, 10'h080, 10'h020, 7'h01, 8'h06);
    lvl <= 2'h1;
    slp(3'h2, 10'h040, 10'h080, 7'h01, 8'h06);
    mask <= 2'h1;
    slp(3'h3, 10'h200, 10'h010, 7'h15, 8'h06);
    gie <= 1'h1;
    slp(3'h3, 10'h000, 10'h200, 7'h15, 8'h06);
    slp(3'h6, 10'h000, 10'h002, 7'h09, 8'h07);
    $display("test sleep done");
    adc_en <= 1'h1;
    repeat (2) @(posedge clk); chk("xconv", xconv, 1);
    adc_st <= 1'h1;
    @(posedge clk) adc_st <= 1'h0;
    @(posedge clk); chk("xconv clr", xconv, 0);
    $display("test adc done");
    conclude();
  end
endmodule
`default_nettype wire
